// ### common/bucket_pkg.sv
// constants for the leaky-bucket activity monitor
// assumes a classic wishbone slave with word-indexed register offsets
package bucket_pkg;
  // printed offsets are not word aligned: kept as indices, byte addr = 4*idx
  localparam logic [7:0] capacity_idx = 8'h5a;
  localparam logic [7:0] drain_idx = 8'h5b;
  localparam logic [7:0] raise_idx = 8'h5c;
  localparam logic [7:0] clear_idx = 8'h5d;  // alarm clear level
  localparam logic [7:0] status_idx = 8'h5e;  // fill level and alarm
  localparam logic [7:0] cycle_idx = 8'h5f;  // monitoring cycle length
  localparam int addr_lsb = 2;
  localparam logic [7:0] capacity_rst = 8'h08;
  localparam logic [7:0] drain_rst = 8'h01;
  localparam logic [7:0] raise_rst = 8'h06;
  localparam logic [7:0] clear_rst = 8'h04;
  localparam logic [7:0] cycle_rst = 8'h7f;  // 128 clocks per cycle
  localparam int drain_lsb = 0;
  localparam int drain_w = 2;
  localparam int alarm_bit = 8;
endpackage

// ### hdl/activity_monitor.sv
// leaky-bucket activity monitor with classic wishbone register slave
// assumes fault_in is asynchronous to sys_clk and held for whole cycles
// and that a bus master holds each request until it samples ack
//
// Contract
// - each faulty monitoring cycle adds one
// - each clean period of 1/2/4/8 cycles subtracts one
// - two-bit drain code picks the period
// - fill never exceeds programmed capacity
// - alarm rises when fill reaches raise level
// - alarm clears when fill drains to clear level
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module activity_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fault_in,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic alarm
);
  logic fault_s1_reg;  // first synchroniser stage
  logic fault_s2_reg;  // synchronised fault level
  logic cycle_fault_reg;  // fault seen anywhere in this cycle
  logic [7:0] cyc_cnt_reg;  // clocks within the monitoring cycle
  logic cycle_tick;  // last clock of the monitoring cycle
  logic fault_seen;  // this cycle has been faulty so far
  logic drain_step;  // a clean period has just completed
  // configuration, one byte each
  logic [7:0] capacity_reg;  // bucket capacity
  logic [7:0] drain_reg;  // drain code in bits 1:0
  logic [7:0] raise_reg;  // fill at which the alarm rises
  logic [7:0] clear_reg;  // fill at which the alarm clears
  logic [7:0] cycle_len_reg;  // monitoring cycle length minus one
  // bucket state
  logic [7:0] fill_reg;  // accumulator
  logic [7:0] fill_next;
  logic alarm_reg;  // inactivity alarm
  logic alarm_next;
  // bus side
  logic ack_reg;  // one-cycle acknowledge
  logic [31:0] rdata_reg;  // read data, held until the next access
  logic [31:0] rdata_next;
  logic [7:0] idx;  // register index of the current address
  logic req;  // request not yet answered
  logic wr_ok;  // write with the low byte lane enabled
  logic hit_capacity;  // address decodes, shared by read and write
  logic hit_drain;
  logic hit_raise;
  logic hit_clear;
  logic hit_status;
  logic hit_cycle;
  logic wr_capacity;  // per-register write strobes
  logic wr_drain;
  logic wr_raise;
  logic wr_clear;
  logic wr_cycle;
  logic fill_up;  // faulty cycle with room left
  logic fill_down;  // drain step with something to drain

  // register index from a byte address
  function automatic logic [7:0] word_idx(input logic [9:0] adr);
    word_idx = adr[9:bucket_pkg::addr_lsb];
  endfunction

  // fault pin crosses two flops before anything reads it
  // the first stage may go metastable, so only the second one is read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_s1_reg <= 1'b0;
      fault_s2_reg <= 1'b0;
    end else begin
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // monitoring cycle: programmable length, fault latched over the cycle;
  // the compare is >= so that shortening the cycle below the running
  // count ends the cycle at once instead of wrapping through 256 clocks
  assign cycle_tick = (cyc_cnt_reg >= cycle_len_reg);
  assign fault_seen = cycle_fault_reg || fault_s2_reg;
  // a fault in the closing clock still counts, as fault_seen is what the tick samples
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cyc_cnt_reg <= 8'h00;
      cycle_fault_reg <= 1'b0;
    end else begin
      cyc_cnt_reg <= cycle_tick ? 8'h00 : cyc_cnt_reg + 8'h01;
      cycle_fault_reg <= cycle_tick ? 1'b0 : fault_seen;
    end
  end

  // clean-period timer; a faulty cycle restarts its count
  drain_timer u_drain (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cycle_tick(cycle_tick),
    .fault_seen(fault_seen),
    .drain_code(drain_reg[bucket_pkg::drain_lsb +: bucket_pkg::drain_w]),
    .drain_step(drain_step)
  );

  // fill moves by one per faulty cycle, capped at capacity
  assign fill_up = cycle_tick && fault_seen && (fill_reg < capacity_reg);
  // drain stops at empty
  assign fill_down = drain_step && (fill_reg != 8'h00);
  // a capacity lowered under the fill pulls the fill down to it
  assign fill_next = (fill_reg > capacity_reg) ? capacity_reg :
                     fill_up ? fill_reg + 8'h01 :
                     fill_down ? fill_reg - 8'h01 : fill_reg;
  // hysteresis: raise on reaching upper, clear at or under lower
  // an empty bucket always reads as active, even with a raise level of
  // zero, so the empty test comes first
  // limitation: a raise level above capacity can never be reached
  assign alarm_next = (fill_next == 8'h00) ? 1'b0 :
                      (fill_next >= raise_reg) ? 1'b1 :
                      (fill_next <= clear_reg) ? 1'b0 : alarm_reg;

  // fill and alarm move on one edge, so a status read is always coherent
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fill_reg <= 8'h00;
      alarm_reg <= 1'b0;
    end else begin
      fill_reg <= fill_next;
      alarm_reg <= alarm_next;  // empty bucket ends low
    end
  end
  assign alarm = alarm_reg;

  // wishbone decode; ack comes one cycle after the request, then drops
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign idx = word_idx(wb_adr_i);
  assign wr_ok = req && wb_we_i && wb_sel_i[0];

  // one decode per register, shared by the read mux and the write strobes
  // so that a read and a write of one address can never disagree
  assign hit_capacity = (idx == bucket_pkg::capacity_idx);
  assign hit_drain = (idx == bucket_pkg::drain_idx);
  assign hit_raise = (idx == bucket_pkg::raise_idx);
  assign hit_clear = (idx == bucket_pkg::clear_idx);
  assign hit_status = (idx == bucket_pkg::status_idx);
  assign hit_cycle = (idx == bucket_pkg::cycle_idx);

  // write strobes; the status word has none, so writing it is ignored
  assign wr_capacity = wr_ok && hit_capacity;
  assign wr_drain = wr_ok && hit_drain;
  assign wr_raise = wr_ok && hit_raise;
  assign wr_clear = wr_ok && hit_clear;
  assign wr_cycle = wr_ok && hit_cycle;

  // read mux; unmapped indices read zero but are still acked
  assign rdata_next =
    hit_capacity ? {24'h0, capacity_reg} :
    hit_drain ? {24'h0, drain_reg} :
    hit_raise ? {24'h0, raise_reg} :
    hit_clear ? {24'h0, clear_reg} :
    hit_cycle ? {24'h0, cycle_len_reg} :
    hit_status ? {23'h0, alarm_reg, fill_reg} :
    32'h0;

  // bucket capacity; lowering it under the fill clamps the fill
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      capacity_reg <= bucket_pkg::capacity_rst;
    end else if (wr_capacity) begin
      capacity_reg <= wb_dat_i[7:0];
    end
  end

  // drain code; the unused upper bits are kept at zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drain_reg <= bucket_pkg::drain_rst;
    end else if (wr_drain) begin
      drain_reg <= {6'h00, wb_dat_i[1:0]};
    end
  end

  // alarm raise level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      raise_reg <= bucket_pkg::raise_rst;
    end else if (wr_raise) begin
      raise_reg <= wb_dat_i[7:0];
    end
  end

  // alarm clear level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clear_reg <= bucket_pkg::clear_rst;
    end else if (wr_clear) begin
      clear_reg <= wb_dat_i[7:0];
    end
  end

  // monitoring cycle length minus one; a shorter value ends a cycle in
  // progress at once, because the tick compare is >=
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cycle_len_reg <= bucket_pkg::cycle_rst;
    end else if (wr_cycle) begin
      cycle_len_reg <= wb_dat_i[7:0];
    end
  end

  // ack and read data
  // read data is caught at the take edge and then held for the master
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      rdata_reg <= req ? rdata_next : rdata_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
endmodule
`default_nettype wire

// ### hdl/drain_timer.sv
// counts clean monitoring cycles and pulses when a drain step is due
// assumes cycle_tick and fault_seen come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module drain_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cycle_tick,
  input wire logic fault_seen,
  input wire logic [1:0] drain_code,
  output logic drain_step
);
  logic [2:0] clean_reg;  // clean cycles in the current period
  logic [2:0] clean_next;
  logic [2:0] period_last;  // period length minus one

  // code n gives 2**n clean cycles per step
  assign period_last = 3'((4'd1 << drain_code) - 4'd1);
  // a fault restarts the clean run >= lets a shorter code take
  // effect at once rather than only after the count has wrapped
  assign drain_step = cycle_tick && !fault_seen && (clean_reg >= period_last);
  assign clean_next = !cycle_tick ? clean_reg :
                      (fault_seen || drain_step) ? 3'h0 :
                      clean_reg + 3'h1;

  // period counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clean_reg <= 3'h0;
    end else begin
      clean_reg <= clean_next;
    end
  end
endmodule
`default_nettype wire

// ### sim/activity_monitor_monitor.sv
// checker for the monitor's bus answers and alarm output
// assumes it is bound into activity_monitor, one clock domain
`timescale 1ns/10ps
`default_nettype none
module activity_monitor_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic alarm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // a request is taken while ack is still low
  wire logic take;
  assign take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  a_ack_after_take: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!take |=> !wb_ack_o)
    else $error("ack without request");
  a_data_stands: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved between accesses");
  a_upper_bits_zero: assert property (wb_ack_o && !wb_we_i |->
    wb_dat_o[31:9] == 23'h0) else $error("upper read bits set");
  a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[9:2] > 8'h5f |-> wb_dat_o == 32'h0) else $error("hole read");
  // the status word carries the alarm pin as it stood at the take edge
  a_status_alarm_bit: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[9:2] == bucket_pkg::status_idx |-> wb_dat_o[8] == $past(alarm))
    else $error("status alarm bit differs from pin");
  // reset must empty the bucket, so the alarm is low right after it
  a_reset_clears_alarm: assert property (disable iff (1'b0) !rst_n |=> !alarm)
    else $error("alarm high after reset");
  cover property ($rose(alarm));
  cover property ($fell(alarm));
  cover property (wb_ack_o && wb_we_i);
endmodule
bind activity_monitor activity_monitor_monitor u_mon (.sys_clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .alarm);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the leaky-bucket activity monitor
// assumes a 4-clock monitoring cycle programmed through the bus
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault_in = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'hf;
  wire logic [31:0] rdat;
  wire logic ack;
  wire logic alarm;
  int fails = 0;
  int checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  activity_monitor DUT (.sys_clk, .rst_n, .fault_in, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .alarm);
  task automatic finish_test;
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits for ack, data taken at that edge
  task automatic bus(input logic w, input logic [7:0] i,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, i, 8'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic t_defaults;
    rd(bucket_pkg::capacity_idx, 32'h08);
    rd(bucket_pkg::drain_idx, 32'h01);
    rd(bucket_pkg::raise_idx, 32'h06);
    rd(8'h60, 32'h0);
    // a write with byte lane 0 off must leave the register alone
    sel <= 4'he;
    wr(bucket_pkg::capacity_idx, 8'h33);
    sel <= 4'hf;
    rd(bucket_pkg::capacity_idx, 32'h08);
  endtask
  // ten faulty cycles must stop at a capacity of five, alarm up
  task automatic t_fill;
    wr(bucket_pkg::cycle_idx, 8'h03);
    wr(bucket_pkg::capacity_idx, 8'h05);
    wr(bucket_pkg::raise_idx, 8'h05);
    wr(bucket_pkg::clear_idx, 8'h02);
    wr(bucket_pkg::drain_idx, 8'h03);
    fault_in <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(bucket_pkg::status_idx, 32'h105);
    chk({31'h0, alarm}, 32'h1);
  endtask
  // slowest drain: one step per 32 clocks, so three steps by now
  task automatic t_drain;
    fault_in <= 1'b0;
    repeat (112) @(posedge sys_clk);
    rd(bucket_pkg::status_idx, 32'h002);
    chk({31'h0, alarm}, 32'h0);
    wr(bucket_pkg::drain_idx, 8'h00);
    repeat (40) @(posedge sys_clk);
    rd(bucket_pkg::status_idx, 32'h000);
    chk({31'h0, alarm}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_defaults;
    t_fill;
    t_drain;
    finish_test;
  end
  // the sequence needs well under 600 clocks
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
